// ---- logic/rtcs_top.sv ----
// slow clock output, timekeeping counters, periodic and alarm interrupts
// assumes xtal_clk runs free at XTAL_HZ; host-side ports are on core_clk
`timescale 1ns/1ns

// What this block does
// - control high gives continuous slow clock output
// - control low holds slow clock output low
// - output starts and stops without truncated pulses
// - backup power return reads halt flag zero
// - seconds write clears sub-second divider stages
// - clearing periodic flag releases interrupt line a
// - codes four to seven select level periods
// - alarm flag clear keeps enable, fires again
// - enabled alarm match sets flag, pulls line low
module rtcs_top #(
  parameter int unsigned XTAL_HZ = rtcs_pkg::SUB_SEC_COUNT
) (
  // clocks and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 xtal_clk,
  // slow clock output pin
  input  wire logic                 clock_output_control,
  output logic                      slow_clock_output,
  // power status
  input  wire logic                 power_from_backup,
  input  wire logic                 osc_halt_clear,
  output logic                      oscillation_halt_flag,
  // time counters
  input  wire logic                 time_write,
  input  wire rtcs_pkg::rtcs_time_t time_wdata,
  output logic                      time_write_busy,
  output rtcs_pkg::rtcs_time_t      time_now,
  output logic                      time_tick,
  // periodic interrupt
  input  wire logic                 periodic_select_2,
  input  wire logic                 periodic_select_1,
  input  wire logic                 periodic_select_0,
  input  wire logic                 periodic_flag_clear,
  output logic                      periodic_irq_flag,
  // alarms
  input  wire logic                 weekly_alarm_enable,
  input  wire logic                 daily_alarm_enable,
  input  wire rtcs_pkg::rtcs_alarm_t weekly_alarm,
  input  wire rtcs_pkg::rtcs_alarm_t daily_alarm,
  input  wire logic                 weekly_flag_clear,
  input  wire logic                 daily_flag_clear,
  output logic                      weekly_alarm_flag,
  output logic                      daily_alarm_flag,
  // open-drain interrupt lines
  output logic                      interrupt_line_a_o,
  output logic                      interrupt_line_a_oe,
  output logic                      interrupt_line_b_o,
  output logic                      interrupt_line_b_oe
);

  localparam int DIVW = $clog2(XTAL_HZ);
  localparam logic [DIVW-1:0] DIV_LAST   = DIVW'(XTAL_HZ - 1);
  localparam logic [DIVW-1:0] DIV_HALF   = DIVW'(XTAL_HZ / 2);
  localparam logic [DIVW-1:0] DIV_QUART  = DIVW'(XTAL_HZ / 4);
  localparam logic [DIVW-1:0] DIV_3QUART = DIVW'((3 * XTAL_HZ) / 4);

  function automatic logic [4:0] month_days(input logic [3:0] m, input logic [6:0] y);
    case (m)
      4'h2:    month_days = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
      4'h4,
      4'h6,
      4'h9,
      4'hB:    month_days = 5'h1E;
      default: month_days = 5'h1F;
    endcase
  endfunction

  function automatic logic is_level(input logic [2:0] sel);
    is_level = sel[2];
  endfunction

  // xtal domain reset, asynchronous assert, synchronous release
  logic x_rst_meta;
  logic x_rst;

  always_ff @(posedge xtal_clk or posedge rst) begin
    if (rst) begin
      x_rst_meta <= 1'b1;
      x_rst      <= 1'b1;
    end else begin
      x_rst_meta <= 1'b0;
      x_rst      <= x_rst_meta;
    end
  end

  // pins and settings into the xtal domain
  logic       x_clk_en;
  logic [2:0] x_psel;

  rtcs_sync #(.W(1)) u_sync_clock_output_control (
    .clk (xtal_clk),
    .rst (x_rst),
    .d   (clock_output_control),
    .q   (x_clk_en)
  );

  // select is a static setting, so per-bit sync is enough
  rtcs_sync #(.W(3)) u_sync_psel (
    .clk (xtal_clk),
    .rst (x_rst),
    .d   ({periodic_select_2, periodic_select_1, periodic_select_0}),
    .q   (x_psel)
  );

  // gated toggle
  // only starts from low and always finishes a high half, so no runt pulse
  always_ff @(posedge xtal_clk or posedge x_rst) begin
    if (x_rst) begin
      slow_clock_output <= 1'b0;
    end else begin
      slow_clock_output <= x_clk_en & ~slow_clock_output;
    end
  end

  // time write crossing; hold register stays put while busy
  rtcs_pkg::rtcs_time_t wr_hold;
  logic                 wr_take;
  logic                 x_wr_ev;
  logic                 wr_ack;

  assign wr_take = time_write & ~time_write_busy;

  rtcs_event_xfer u_wr_xfer (
    .src_clk   (core_clk),
    .src_rst   (rst),
    .src_pulse (wr_take),
    .dst_clk   (xtal_clk),
    .dst_rst   (x_rst),
    .dst_pulse (x_wr_ev)
  );

  rtcs_event_xfer u_ack_xfer (
    .src_clk   (xtal_clk),
    .src_rst   (x_rst),
    .src_pulse (x_wr_ev),
    .dst_clk   (core_clk),
    .dst_rst   (rst),
    .dst_pulse (wr_ack)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_hold         <= rtcs_pkg::TIME_RESET;
      time_write_busy <= 1'b0;
    end else begin
      if (wr_take) begin
        wr_hold <= time_wdata;
      end
      time_write_busy <= wr_take | (time_write_busy & ~wr_ack);
    end
  end

  // sub-second divider
  logic [DIVW-1:0] sub_count;
  logic            sec_tick;

  assign sec_tick = (sub_count == DIV_LAST) & ~x_wr_ev;

  always_ff @(posedge xtal_clk or posedge x_rst) begin
    if (x_rst) begin
      sub_count <= '0;
    end else if (x_wr_ev || sub_count == DIV_LAST) begin
      sub_count <= '0;
    end else begin
      sub_count <= sub_count + 1'b1;
    end
  end

  // time and calendar counters
  rtcs_pkg::rtcs_time_t cur;
  rtcs_pkg::rtcs_time_t next_cur;
  logic                 min_roll;
  logic                 hour_roll;
  logic                 month_roll;

  always_comb begin
    next_cur   = cur;
    min_roll   = 1'b0;
    hour_roll  = 1'b0;
    month_roll = 1'b0;
    if (x_wr_ev) begin
      next_cur = wr_hold;
    end else if (sec_tick) begin
      if (cur.second < rtcs_pkg::SEC_LAST) begin
        next_cur.second = cur.second + 6'h01;
      end else begin
        next_cur.second = 6'h00;
        min_roll        = 1'b1;
        if (cur.minute < rtcs_pkg::MIN_LAST) begin
          next_cur.minute = cur.minute + 6'h01;
        end else begin
          next_cur.minute = 6'h00;
          hour_roll       = 1'b1;
          if (cur.hour < rtcs_pkg::HOUR_LAST) begin
            next_cur.hour = cur.hour + 5'h01;
          end else begin
            next_cur.hour    = 5'h00;
            next_cur.weekday = (cur.weekday < rtcs_pkg::WDAY_LAST) ?
                               cur.weekday + 3'h1 : 3'h0;
            if (cur.day < month_days(cur.month, cur.year)) begin
              next_cur.day = cur.day + 5'h01;
            end else begin
              next_cur.day = 5'h01;
              month_roll   = 1'b1;
              if (cur.month < rtcs_pkg::MONTH_LAST) begin
                next_cur.month = cur.month + 4'h1;
              end else begin
                next_cur.month = 4'h1;
                next_cur.year  = (cur.year < rtcs_pkg::YEAR_LAST) ?
                                 cur.year + 7'h01 : 7'h00;
              end
            end
          end
        end
      end
    end
  end

  // shadow copy is stable for a whole second, so the core reads it whole
  rtcs_pkg::rtcs_time_t shadow;
  logic                 snap_pulse;

  always_ff @(posedge xtal_clk or posedge x_rst) begin
    if (x_rst) begin
      cur        <= rtcs_pkg::TIME_RESET;
      shadow     <= rtcs_pkg::TIME_RESET;
      snap_pulse <= 1'b0;
    end else begin
      cur        <= next_cur;
      snap_pulse <= x_wr_ev | sec_tick;
      if (x_wr_ev || sec_tick) begin
        shadow <= next_cur;
      end
    end
  end

  // periodic waveform and level events
  logic level_ev;
  logic pulse_low;

  always_comb begin
    case (x_psel)
      rtcs_pkg::PSEL_SEC:   level_ev = sec_tick;
      rtcs_pkg::PSEL_MIN:   level_ev = min_roll;
      rtcs_pkg::PSEL_HOUR:  level_ev = hour_roll;
      rtcs_pkg::PSEL_MONTH: level_ev = month_roll;
      default:              level_ev = 1'b0;
    endcase
  end

  always_ff @(posedge xtal_clk or posedge x_rst) begin
    if (x_rst) begin
      pulse_low <= 1'b0;
    end else if (x_psel == rtcs_pkg::PSEL_1HZ) begin
      pulse_low <= (sub_count < DIV_HALF);
    end else begin
      pulse_low <= (sub_count < DIV_QUART) |
                   ((sub_count >= DIV_HALF) & (sub_count < DIV_3QUART));
    end
  end

  // back into the core domain
  logic snap_ev;
  logic core_level_ev;
  logic core_pulse_low;
  logic backup_sync;

  rtcs_event_xfer u_snap_xfer (
    .src_clk   (xtal_clk),
    .src_rst   (x_rst),
    .src_pulse (snap_pulse),
    .dst_clk   (core_clk),
    .dst_rst   (rst),
    .dst_pulse (snap_ev)
  );

  rtcs_event_xfer u_level_xfer (
    .src_clk   (xtal_clk),
    .src_rst   (x_rst),
    .src_pulse (level_ev),
    .dst_clk   (core_clk),
    .dst_rst   (rst),
    .dst_pulse (core_level_ev)
  );

  rtcs_sync #(.W(1)) u_sync_pulse (
    .clk (core_clk),
    .rst (rst),
    .d   (pulse_low),
    .q   (core_pulse_low)
  );

  rtcs_sync #(.W(1)) u_sync_backup (
    .clk (core_clk),
    .rst (rst),
    .d   (power_from_backup),
    .q   (backup_sync)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      time_now  <= rtcs_pkg::TIME_RESET;
      time_tick <= 1'b0;
    end else begin
      time_tick <= snap_ev;
      if (snap_ev) begin
        time_now <= shadow;
      end
    end
  end

  // oscillation halt flag; backup strap caught once the sync has filled
  logic [1:0] start_cnt;
  logic       start_done;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      start_cnt             <= 2'h0;
      start_done            <= 1'b0;
      oscillation_halt_flag <= rtcs_pkg::HALT_RESET;
    end else if (!start_done) begin
      start_cnt <= start_cnt + 2'h1;
      if (start_cnt == rtcs_pkg::START_WAIT) begin
        start_done <= 1'b1;
        oscillation_halt_flag <= ~backup_sync;
      end
    end else if (osc_halt_clear) begin
      oscillation_halt_flag <= 1'b0;
    end
  end

  // alarm compare on each new minute
  logic [2:0] core_psel;
  logic       new_minute;
  logic       weekly_hit;
  logic       daily_hit;

  assign core_psel  = {periodic_select_2, periodic_select_1, periodic_select_0};
  assign new_minute = snap_ev & (shadow.second == 6'h00);
  assign weekly_hit = new_minute & weekly_alarm_enable &
                      weekly_alarm.weekday_mask[shadow.weekday] &
                      (weekly_alarm.hour == shadow.hour) &
                      (weekly_alarm.minute == shadow.minute);
  assign daily_hit  = new_minute & daily_alarm_enable &
                      (daily_alarm.hour == shadow.hour) &
                      (daily_alarm.minute == shadow.minute);

  // flags: set wins over clear; disabling an alarm drops its flag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      weekly_alarm_flag <= 1'b0;
      daily_alarm_flag  <= 1'b0;
    end else begin
      weekly_alarm_flag <= weekly_hit |
                           (weekly_alarm_flag & ~weekly_flag_clear & weekly_alarm_enable);
      daily_alarm_flag  <= daily_hit |
                           (daily_alarm_flag & ~daily_flag_clear & daily_alarm_enable);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      periodic_irq_flag <= 1'b0;
    end else begin
      periodic_irq_flag <= (core_level_ev & is_level(core_psel)) |
                           (periodic_irq_flag & ~periodic_flag_clear & is_level(core_psel));
    end
  end

  // interrupt line drive; line a is the OR of its low-active sources
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      interrupt_line_a_o  <= 1'b0;
      interrupt_line_a_oe <= 1'b0;
      interrupt_line_b_o  <= 1'b0;
      interrupt_line_b_oe <= 1'b0;
    end else begin
      interrupt_line_a_o  <= 1'b0;
      interrupt_line_b_o  <= 1'b0;
      interrupt_line_b_oe <= weekly_alarm_flag;
      interrupt_line_a_oe <= daily_alarm_flag |
                             periodic_irq_flag |
                             (core_psel == rtcs_pkg::PSEL_LOW) |
                             (((core_psel == rtcs_pkg::PSEL_2HZ) ||
                               (core_psel == rtcs_pkg::PSEL_1HZ)) & core_pulse_low);
    end
  end

endmodule // rtcs_top

// ---- shared/rtcs_pkg.sv ----
// shared constants and carriers for the clock-output and timekeeping block
// assumes a link clock at twice the slow clock output rate
package rtcs_pkg;

  // link clock rate and the sub-second divider
  localparam int unsigned CLK_OUT_HZ    = 32768;
  localparam int unsigned XTAL_HZ_DEF   = 2 * CLK_OUT_HZ;
  localparam int unsigned SEC_PERIOD_S  = 1;
  localparam int unsigned SUB_SEC_COUNT = SEC_PERIOD_S * XTAL_HZ_DEF;

  // periodic select codes
  localparam logic [2:0] PSEL_OFF   = 3'h0;
  localparam logic [2:0] PSEL_LOW   = 3'h1;
  localparam logic [2:0] PSEL_2HZ   = 3'h2;
  localparam logic [2:0] PSEL_1HZ   = 3'h3;
  localparam logic [2:0] PSEL_SEC   = 3'h4;
  localparam logic [2:0] PSEL_MIN   = 3'h5;
  localparam logic [2:0] PSEL_HOUR  = 3'h6;
  localparam logic [2:0] PSEL_MONTH = 3'h7;

  // counter limits
  localparam logic [5:0] SEC_LAST   = 6'h3B;
  localparam logic [5:0] MIN_LAST   = 6'h3B;
  localparam logic [4:0] HOUR_LAST  = 5'h17;
  localparam logic [2:0] WDAY_LAST  = 3'h6;
  localparam logic [3:0] MONTH_LAST = 4'hC;
  localparam logic [6:0] YEAR_LAST  = 7'h63;

  // time and calendar counters, binary coded
  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [2:0] weekday;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } rtcs_time_t;

  // alarm preset; weekday_mask is ignored by the daily alarm
  typedef struct packed {
    logic [6:0] weekday_mask;
    logic [4:0] hour;
    logic [5:0] minute;
  } rtcs_alarm_t;

  // reset values
  localparam rtcs_time_t TIME_RESET = '{year: 7'h00, month: 4'h1, day: 5'h01,
                                        weekday: 3'h0, hour: 5'h00, minute: 6'h00,
                                        second: 6'h00};
  localparam logic       HALT_RESET = 1'b1;
  localparam logic [1:0] START_WAIT = 2'h2;

endpackage

// ---- logic/rtcs_sync.sv ----
// two-flop level synchroniser, parameterised width
// assumes each bit is a slow level; multi-bit use only for static settings
`timescale 1ns/1ns
module rtcs_sync #(
  parameter int W = 1
) (
  // clock and reset of the receiving domain
  input  wire logic         clk,
  input  wire logic         rst,
  // level in and out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // rtcs_sync

// ---- logic/rtcs_event_xfer.sv ----
// one-cycle event crossing by toggle
// assumes events in the source domain are spaced by at least three
// destination cycles; closer ones can cancel in pairs
`timescale 1ns/1ns
module rtcs_event_xfer (
  // source side
  input  wire logic src_clk,
  input  wire logic src_rst,
  input  wire logic src_pulse,
  // destination side
  input  wire logic dst_clk,
  input  wire logic dst_rst,
  output logic      dst_pulse
);

  logic src_toggle;
  logic dst_meta;
  logic dst_sync;
  logic dst_last;

  always_ff @(posedge src_clk or posedge src_rst) begin
    if (src_rst) begin
      src_toggle <= 1'b0;
    end else if (src_pulse) begin
      src_toggle <= ~src_toggle;
    end
  end

  always_ff @(posedge dst_clk or posedge dst_rst) begin
    if (dst_rst) begin
      dst_meta  <= 1'b0;
      dst_sync  <= 1'b0;
      dst_last  <= 1'b0;
      dst_pulse <= 1'b0;
    end else begin
      dst_meta  <= src_toggle;
      dst_sync  <= dst_meta;
      dst_last  <= dst_sync;
      dst_pulse <= dst_sync ^ dst_last;
    end
  end

endmodule // rtcs_event_xfer

// ---- sim/rtcs_top_asserts.sv ----
// port checker for rtcs_top, bound to every instance
// assumes host strobes keep clear of the second boundary
`timescale 1ns/1ns
module rtcs_top_chk (
  // clocks and reset
  input wire logic                  core_clk,
  input wire logic                  rst,
  input wire logic                  xtal_clk,
  // slow clock and power
  input wire logic                  clock_output_control,
  input wire logic                  slow_clock_output,
  input wire logic                  power_from_backup,
  input wire logic                  osc_halt_clear,
  input wire logic                  oscillation_halt_flag,
  // time, periodic, alarms
  input wire logic                  time_tick,
  input wire rtcs_pkg::rtcs_time_t  time_now,
  input wire logic                  periodic_select_2,
  input wire logic                  periodic_flag_clear,
  input wire logic                  periodic_irq_flag,
  input wire logic                  daily_alarm_enable,
  input wire rtcs_pkg::rtcs_alarm_t weekly_alarm,
  input wire logic                  weekly_flag_clear,
  input wire logic                  weekly_alarm_flag,
  input wire logic                  interrupt_line_a_oe,
  input wire logic                  interrupt_line_b_oe
);
  a_clk_runs: assert property (@(posedge xtal_clk) disable iff (rst)
    clock_output_control [*8] |-> slow_clock_output != $past(slow_clock_output))
    else $error("slow clock not toggling while enabled");
  a_clk_idle: assert property (@(posedge xtal_clk) disable iff (rst)
    !clock_output_control [*5] |-> !slow_clock_output)
    else $error("slow clock high while disabled");
  a_high_whole: assert property (@(posedge xtal_clk) disable iff (rst)
    $rose(slow_clock_output) |=> $fell(slow_clock_output))
    else $error("slow clock high half not one period");
  a_halt_clear: assert property (@(posedge core_clk) disable iff (rst)
    osc_halt_clear |=> !oscillation_halt_flag)
    else $error("halt flag not cleared");
  a_halt_keep: assert property (@(posedge core_clk) disable iff (rst)
    oscillation_halt_flag && !osc_halt_clear && !power_from_backup |=> oscillation_halt_flag)
    else $error("halt flag dropped by itself");
  a_backup_zero: assert property (@(posedge core_clk) disable iff (rst)
    power_from_backup [*5] |-> !oscillation_halt_flag)
    else $error("halt flag set after backup return");
  a_irq_release: assert property (@(posedge core_clk) disable iff (rst)
    periodic_flag_clear && periodic_select_2 && !daily_alarm_enable
    |=> !periodic_irq_flag ##1 !interrupt_line_a_oe)
    else $error("periodic clear did not release line a");
  a_level_only: assert property (@(posedge core_clk) disable iff (rst)
    $rose(periodic_irq_flag) |-> periodic_select_2)
    else $error("periodic flag set outside level mode");
  a_alarm_match: assert property (@(posedge core_clk) disable iff (rst)
    $rose(weekly_alarm_flag) |-> time_tick && time_now.second == 6'h00
    && time_now.minute == weekly_alarm.minute && time_now.hour == weekly_alarm.hour
    && weekly_alarm.weekday_mask[time_now.weekday])
    else $error("weekly flag set without a match");
  a_line_b: assert property (@(posedge core_clk) disable iff (rst)
    interrupt_line_b_oe == $past(weekly_alarm_flag))
    else $error("line b does not follow weekly flag");
  a_alarm_clear: assert property (@(posedge core_clk) disable iff (rst)
    weekly_flag_clear |=> !weekly_alarm_flag)
    else $error("weekly flag not cleared");
endmodule // rtcs_top_chk

bind rtcs_top rtcs_top_chk i_chk (.*);

// ---- sim/rtcs_host.sv ----
// host model driving the host-side strobes and settings of rtcs_top
// assumes the bench clock; everything changes at falling edges
`timescale 1ns/1ns
module rtcs_host #(
  parameter int unsigned XTAL_HZ = 16
) (
  // clock and answers
  input  wire logic             core_clk,
  input  wire logic             time_write_busy,
  input  wire logic             time_tick,
  // requests and settings
  output logic                  time_write,
  output rtcs_pkg::rtcs_time_t  time_wdata,
  output logic                  osc_halt_clear,
  output logic                  periodic_flag_clear,
  output logic                  weekly_flag_clear,
  output logic                  daily_flag_clear,
  output logic                  periodic_select_2,
  output logic                  periodic_select_1,
  output logic                  periodic_select_0,
  output logic                  weekly_alarm_enable,
  output logic                  daily_alarm_enable,
  output rtcs_pkg::rtcs_alarm_t weekly_alarm,
  output rtcs_pkg::rtcs_alarm_t daily_alarm
);
  initial begin
    {time_write, osc_halt_clear, periodic_flag_clear, weekly_flag_clear} = 4'h0;
    {daily_flag_clear, periodic_select_2, periodic_select_1, periodic_select_0} = 4'h0;
    {weekly_alarm_enable, daily_alarm_enable} = 2'h0;
    time_wdata = '0;
    weekly_alarm = '0;
    daily_alarm = '0;
  end
  task automatic boot();
    repeat (XTAL_HZ * 8 + 20) @(negedge core_clk);
  endtask
  // clear strobes: halt, periodic, weekly, daily
  task automatic pulse(input logic [3:0] m);
    {osc_halt_clear, periodic_flag_clear, weekly_flag_clear, daily_flag_clear} = m;
    @(negedge core_clk);
    {osc_halt_clear, periodic_flag_clear, weekly_flag_clear, daily_flag_clear} = 4'h0;
  endtask
  task automatic set_sel(input logic [2:0] c);
    {periodic_select_2, periodic_select_1, periodic_select_0} = c;
  endtask
  task automatic wait_tick(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < XTAL_HZ * 16 && !ok; i++) begin
      @(negedge core_clk);
      ok = (time_tick === 1'b1);
    end
  endtask
  // whole counter set in one short request
  task automatic write_time(input rtcs_pkg::rtcs_time_t t, output logic ok);
    for (int i = 0; i < 64 && time_write_busy !== 1'b0; i++)
      @(negedge core_clk);
    time_wdata = t;
    time_write = 1'b1;
    @(negedge core_clk);
    time_write = 1'b0;
    // released data bus shows no stale value
    time_wdata = ~t;
    // a tick already in flight reaches the core before the write's acknowledge
    for (int i = 0; i < 64 && time_write_busy !== 1'b0; i++)
      @(negedge core_clk);
    wait_tick(ok);
  endtask
  task automatic set_alarm(input rtcs_pkg::rtcs_alarm_t a, input logic en);
    {weekly_alarm_enable, daily_alarm_enable} = 2'h0;
    @(negedge core_clk);
    weekly_alarm = a;
    daily_alarm = a;
    @(negedge core_clk);
    {weekly_alarm_enable, daily_alarm_enable} = {en, en};
  endtask
endmodule // rtcs_host

// ---- sim/tb_rtcs_top.sv ----
// self-checking bench for rtcs_top with the host model
// assumes a shortened second of XH crystal cycles
`timescale 1ns/1ns
module tb_rtcs_top;
  localparam int unsigned XH = 16;
  logic core_clk = 1'b0, xtal_clk = 1'b0, rst = 1'b1;
  logic clock_output_control = 1'b0, power_from_backup = 1'b0;
  logic slow_clock_output, oscillation_halt_flag, time_write_busy, time_tick;
  logic periodic_irq_flag, weekly_alarm_flag, daily_alarm_flag;
  logic interrupt_line_a_o, interrupt_line_a_oe, interrupt_line_b_o, interrupt_line_b_oe;
  logic time_write, osc_halt_clear, periodic_flag_clear, weekly_flag_clear, daily_flag_clear;
  logic periodic_select_2, periodic_select_1, periodic_select_0;
  logic weekly_alarm_enable, daily_alarm_enable;
  rtcs_pkg::rtcs_time_t  time_wdata, time_now, t, pre [4];
  rtcs_pkg::rtcs_alarm_t weekly_alarm, daily_alarm;
  // open-drain lines with pull-ups
  wire line_a = interrupt_line_a_oe ? interrupt_line_a_o : 1'b1;
  wire line_b = interrupt_line_b_oe ? interrupt_line_b_o : 1'b1;
  int n_errors = 0, checks = 0, cyc = 0;
  logic ok, p, stopped;
  realtime t0;

  rtcs_top #(.XTAL_HZ(XH)) i_dut (.*);
  rtcs_host #(.XTAL_HZ(XH)) i_host (.*);

  always #4 core_clk = ~core_clk;
  // crystal phase offset keeps crystal edges clear of core clock edges
  initial #3 forever #32 xtal_clk = ~xtal_clk;

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (n_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    pre[0] = '{7'h01, 4'h3, 5'h0A, 3'h2, 5'h03, 6'h04, 6'h10};
    pre[1] = '{7'h01, 4'h3, 5'h0A, 3'h2, 5'h03, 6'h05, 6'h3A};
    pre[2] = '{7'h01, 4'h3, 5'h0A, 3'h2, 5'h03, 6'h3B, 6'h3A};
    pre[3] = '{7'h01, 4'h1, 5'h1F, 3'h2, 5'h17, 6'h3B, 6'h3A};
    // reset spans several crystal periods for the slow domain
    repeat (5) @(negedge xtal_clk);
    @(negedge core_clk);
    rst = 1'b0;
    i_host.boot();
    check("halt_cold", oscillation_halt_flag, 1'b1);
    i_host.pulse(4'h8);
    @(negedge core_clk);
    check("halt_cleared", oscillation_halt_flag, 1'b0);
    clock_output_control = 1'b1;
    repeat (5) @(negedge xtal_clk);
    p = slow_clock_output;
    repeat (16) begin
      @(negedge xtal_clk);
      check("clk_toggle", slow_clock_output !== p, 1'b1);
      p = slow_clock_output;
    end
    @(negedge core_clk);
    clock_output_control = 1'b0;
    stopped = 1'b0;
    repeat (12) begin
      @(negedge xtal_clk);
      stopped = stopped || (slow_clock_output === p);
      if (stopped)
        check("clk_idle", slow_clock_output, 1'b0);
      p = slow_clock_output;
    end
    // mid-second rewrite must restart the full second
    t = '{7'h05, 4'hC, 5'h1F, 3'h6, 5'h17, 6'h3B, 6'h3B};
    for (int i = 0; i < 2; i++) begin
      repeat (37 + 33 * i) @(negedge core_clk);
      i_host.write_time(t, ok); // full init whatever the flag
      check("write_tick", {ok, time_write_busy, time_now}, {2'h2, t});
      t0 = $realtime;
      i_host.wait_tick(ok);
      check("sec_len", ($realtime - t0 > 950) && ($realtime - t0 < 1100), 1'b1);
      check("rollover", time_now, {7'h06, 4'h1, 5'h01, 3'h0, 17'h0});
    end
    for (int c = 4; c < 8; c++) begin
      i_host.set_sel(c[2:0]);
      i_host.write_time(pre[c-4], ok);
      repeat (3) @(negedge core_clk);
      i_host.pulse(4'h4);
      for (int k = (c == 4) ? 1 : 0; k < 2; k++) begin
        i_host.wait_tick(ok);
        repeat (40) @(negedge core_clk);
        check("periodic_flag", {periodic_irq_flag, line_a}, {k == 1, k != 1});
        check("sec", time_now.second, (c == 4) ? 6'h11 : (k == 1) ? 6'h00 : 6'h3B);
      end
      i_host.pulse(4'h4);
      @(negedge core_clk);
      check("periodic_release", {periodic_irq_flag, line_a}, 2'h1);
    end
    // fixed low and 1 Hz pulse codes
    i_host.set_sel(3'h1);
    repeat (20) @(negedge core_clk);
    check("fixed_low", line_a, 1'b0);
    i_host.set_sel(3'h3);
    repeat (20) @(negedge core_clk);
    i_host.wait_tick(ok);
    repeat (20) @(negedge core_clk);
    check("pulse_low", line_a, 1'b0);
    repeat (60) @(negedge core_clk);
    check("pulse_high", line_a, 1'b1);
    i_host.set_sel(3'h0);
    i_host.set_alarm('{7'h04, 5'h03, 6'h05}, 1'b1);
    for (int r = 0; r < 3; r++) begin
      if (r == 2)
        i_host.set_alarm('{7'h00, 5'h1F, 6'h3F}, 1'b1);
      i_host.write_time(pre[0] | 36'h3A, ok);
      repeat (2) i_host.wait_tick(ok);
      repeat (40) @(negedge core_clk);
      check("alarm_fire", {weekly_alarm_flag, daily_alarm_flag, line_b, line_a},
            (r < 2) ? 4'hC : 4'h3);
      i_host.pulse(4'h3);
      @(negedge core_clk);
      check("alarm_clear", {weekly_alarm_flag, daily_alarm_flag, line_b, line_a,
            weekly_alarm_enable, daily_alarm_enable}, 6'h0F);
    end
    power_from_backup = 1'b1;
    rst = 1'b1;
    repeat (5) @(negedge xtal_clk);
    @(negedge core_clk);
    rst = 1'b0;
    repeat (10) @(negedge core_clk);
    check("halt_backup", oscillation_halt_flag, 1'b0);
    stop_test();
  end
endmodule // tb_rtcs_top
